// File: verilog/output_driver_config_regs.sv
// Register bank steering the primary and secondary clock output drivers.
//
// What this block does
// - Primary override 0 follows standard pin; 1 uses primary bits 7:1.
// - Source bit 3: 0 routes first post-divider, 1 routes input reference.
// - Secondary bit 7 selects drive: 0 weak, 1 strong (default).
// - Secondary bit 6 set powers down the driver; default active.
// - Mode bits 5:3: CMOS variants, LVDS, LVPECL default; 110/111 unused.
// - Polarity bits 2:1 set CMOS pin polarity; 00 default.
// - Polarity is ignored when mode selects LVDS or LVPECL.
// - Secondary override 0 follows standard pin; 1 uses bits 7:1.
// - Primary register has the same fields and encodings as secondary.
`include "out_drv_cfg.svh"
`timescale 1ns/1ps
module output_driver_config_regs (
	// Clock and reset
	input  wire logic                    clk_sys_i,
	input  wire logic                    rst_b_i,
	// Register access from the serial control port
	input  wire logic                    reg_wr_i,
	input  wire logic [7:0]              reg_addr_i,
	input  wire logic [7:0]              reg_wdata_i,
	output logic      [7:0]              reg_rdata_o,
	// Output standard select pin, 0 LVDS, 1 LVPECL
	input  wire logic                    output_standard_select_pin_i,
	// Primary driver controls
	output logic                         pri_drive_strong_o,
	output logic                         pri_power_down_o,
	output out_drv_pkg::drv_mode_t       pri_mode_o,
	output out_drv_pkg::drv_pol_t        pri_pol_o,
	// Secondary driver controls
	output logic                         sec_src_reference_o,
	output logic                         sec_drive_strong_o,
	output logic                         sec_power_down_o,
	output out_drv_pkg::drv_mode_t       sec_mode_o,
	output out_drv_pkg::drv_pol_t        sec_pol_o
);
	import out_drv_pkg::*;

	// Channel 0 is the primary driver and channel 1 the secondary. Both
	// share one field layout, so a single generate loop serves them.
	localparam int unsigned NUM_DRV = 2;

	// Reset synchroniser.
	logic                         rst_meta_reg;
	logic                         rst_sync_b_reg;

	// Register file and read path.
	logic [NUM_DRV-1:0][7:0]      ctrl_val;
	logic [7:0]                   src_reg;
	logic [7:0]                   src_next;
	logic [7:0]                   rdata_next;

	// Decoded write strobes.
	logic                         wr_pri;
	logic                         wr_src;
	logic                         wr_sec;
	logic [NUM_DRV-1:0]           wr_ctrl;

	// Effective driver controls, one entry per channel.
	logic [NUM_DRV-1:0]           strong_eff;
	logic [NUM_DRV-1:0]           pd_eff;
	logic [NUM_DRV-1:0][2:0]      mode_eff;
	logic [NUM_DRV-1:0][1:0]      pol_eff;

	// The release of reset passes two flip-flops so that no register
	// leaves reset on an edge where the release may still be settling.
	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_meta_reg   <= 1'b0;
			rst_sync_b_reg <= 1'b0;
		end else begin
			rst_meta_reg   <= 1'b1;
			rst_sync_b_reg <= rst_meta_reg;
		end
	end

	// Unmapped addresses fall through to the default and are dropped.
	always_comb begin
		wr_pri = 1'b0;
		wr_src = 1'b0;
		wr_sec = 1'b0;
		if (reg_wr_i) begin
			unique case (reg_addr_i)
				`ADDR_PRIMARY_CTRL: begin
					wr_pri = 1'b1;
				end
				`ADDR_SECONDARY_SRC: begin
					wr_src = 1'b1;
				end
				`ADDR_SECONDARY_CTRL: begin
					wr_sec = 1'b1;
				end
				default: begin
					wr_pri = 1'b0;
				end
			endcase
		end
	end

	assign wr_ctrl = {wr_sec, wr_pri};

	// Only the source bit is stored, so the unused bits read back as zero.
	always_comb begin
		src_next = src_reg;
		if (wr_src) begin
			src_next = reg_wdata_i & `SRC_MASK;
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_sync_b_reg) begin
		if (!rst_sync_b_reg) begin
			src_reg <= `SRC_RESET;
		end else begin
			src_reg <= src_next;
		end
	end

	for (genvar ch = 0; ch < NUM_DRV; ch++) begin : g_drv
		logic [7:0] ctrl_reg;
		logic [7:0] ctrl_next;
		logic [7:0] eff;
		logic       mode_unused;

		always_comb begin
			ctrl_next = ctrl_reg;
			if (wr_ctrl[ch]) begin
				ctrl_next = reg_wdata_i & `CTRL_MASK;
			end
		end

		always_ff @(posedge clk_sys_i or negedge rst_sync_b_reg) begin
			if (!rst_sync_b_reg) begin
				ctrl_reg <= `CTRL_RESET;
			end else begin
				ctrl_reg <= ctrl_next;
			end
		end

		// Without override the pin picks LVDS or LVPECL and the other
		// fields keep their defaults, so software edits to the stored
		// fields take effect only once the override bit is set.
		always_comb begin
			eff = `CTRL_RESET;
			if (ctrl_reg[`BIT_SW_OVERRIDE]) begin
				eff = ctrl_reg;
			end else if (output_standard_select_pin_i) begin
				eff[`MODE_HI:`MODE_LO] = MODE_LVPECL;
			end else begin
				eff[`MODE_HI:`MODE_LO] = MODE_LVDS;
			end
			mode_unused = eff[`MODE_HI] && eff[`MODE_HI-1];
			// Codes 110 and 111 name no driver; powering down is the
			// only safe reading of them.
			if (mode_unused) begin
				eff[`BIT_POWER_DOWN] = 1'b1;
			end
			// Polarity means something to the CMOS modes only.
			if (eff[`MODE_HI]) begin
				eff[`POL_HI:`POL_LO] = 2'h0;
			end
		end

		assign ctrl_val[ch]   = ctrl_reg;
		assign strong_eff[ch] = eff[`BIT_DRIVE_STRONG];
		assign pd_eff[ch]     = eff[`BIT_POWER_DOWN];
		assign mode_eff[ch]   = eff[`MODE_HI:`MODE_LO];
		assign pol_eff[ch]    = eff[`POL_HI:`POL_LO];
	end

	// Control registers read back all eight bits, override bit included.
	always_comb begin
		unique case (reg_addr_i)
			`ADDR_PRIMARY_CTRL: begin
				rdata_next = ctrl_val[0];
			end
			`ADDR_SECONDARY_SRC: begin
				rdata_next = src_reg;
			end
			`ADDR_SECONDARY_CTRL: begin
				rdata_next = ctrl_val[1];
			end
			default: begin
				rdata_next = 8'h00;
			end
		endcase
	end

	// Read data is registered: one cycle behind the address, which costs
	// a cycle of latency but keeps the address pins off the data pins.
	always_ff @(posedge clk_sys_i or negedge rst_sync_b_reg) begin
		if (!rst_sync_b_reg) begin
			reg_rdata_o <= 8'h00;
		end else begin
			reg_rdata_o <= rdata_next;
		end
	end

	// Primary driver controls.
	assign pri_drive_strong_o  = strong_eff[0];
	assign pri_power_down_o    = pd_eff[0];
	assign pri_mode_o          = drv_mode_t'(mode_eff[0]);
	assign pri_pol_o           = pol_eff[0];

	// Secondary driver controls.
	assign sec_src_reference_o = src_reg[`BIT_SRC_SEL];
	assign sec_drive_strong_o  = strong_eff[1];
	assign sec_power_down_o    = pd_eff[1];
	assign sec_mode_o          = drv_mode_t'(mode_eff[1]);
	assign sec_pol_o           = pol_eff[1];
endmodule

// File: shared/out_drv_cfg.svh
// Register offsets, field positions and reset values for the driver config.
`ifndef OUT_DRV_CFG_SVH
`define OUT_DRV_CFG_SVH
`define ADDR_PRIMARY_CTRL   8'h32
`define ADDR_SECONDARY_SRC  8'h33
`define ADDR_SECONDARY_CTRL 8'h34
`define BIT_DRIVE_STRONG    7
`define BIT_POWER_DOWN      6
`define MODE_HI             5
`define MODE_LO             3
`define POL_HI              2
`define POL_LO              1
`define BIT_SW_OVERRIDE     0
`define BIT_SRC_SEL         3
`define CTRL_RESET          8'ha8
`define SRC_RESET           8'h00
`define SRC_MASK            8'h08
`define CTRL_MASK           8'hff
`endif

// File: shared/out_drv_pkg.sv
// Types shared by the output driver configuration registers.
package out_drv_pkg;
	typedef enum logic [2:0] {
		MODE_CMOS_BOTH = 3'h0,
		MODE_CMOS_POS  = 3'h1,
		MODE_CMOS_NEG  = 3'h2,
		MODE_CMOS_NONE = 3'h3,
		MODE_LVDS      = 3'h4,
		MODE_LVPECL    = 3'h5,
		MODE_UNUSED6   = 3'h6,
		MODE_UNUSED7   = 3'h7
	} drv_mode_t;
	typedef logic [1:0] drv_pol_t;
endpackage

// File: bench/output_driver_config_regs_sva.sv
// Assertions on the output driver register bank ports.
`timescale 1ns/1ps
module output_driver_config_regs_sva (
	input wire logic       clk_sys_i,
	input wire logic       rst_b_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       output_standard_select_pin_i,
	input wire logic       sec_src_reference_o,
	input wire logic       sec_drive_strong_o,
	input wire logic       sec_power_down_o,
	input wire logic [2:0] pri_mode_o,
	input wire logic [2:0] sec_mode_o,
	input wire logic [1:0] sec_pol_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	wire [7:0] d = reg_wdata_i;
	wire w4 = reg_wr_i && reg_addr_i == 8'h34;
	wire on = w4 && d[0];
	property p_src; reg_wr_i && reg_addr_i == 8'h33 |=>
		sec_src_reference_o == $past(d[3]); endproperty
	a_src: assert property (p_src) else $error("source");
	property p_pri; reg_wr_i && reg_addr_i == 8'h32 && d[0] |=>
		pri_mode_o == $past(d[5:3]); endproperty
	a_pri: assert property (p_pri) else $error("pri mode");
	property p_str; on |=> sec_drive_strong_o == $past(d[7]); endproperty
	a_str: assert property (p_str) else $error("drive");
	property p_pd; on && !d[5] |=> sec_power_down_o == $past(d[6]); endproperty
	a_pd: assert property (p_pd) else $error("power");
	property p_mode; on |=> sec_mode_o == $past(d[5:3]); endproperty
	a_mode: assert property (p_mode) else $error("mode");
	property p_pol; on && !d[5] |=> sec_pol_o == $past(d[2:1]); endproperty
	a_pol: assert property (p_pol) else $error("polarity");
	property p_ign; sec_mode_o[2] |-> sec_pol_o == 2'b00; endproperty
	a_ign: assert property (p_ign) else $error("pol used");
	property p_ovr; w4 && !d[0] |=>
		sec_mode_o == {2'b10, output_standard_select_pin_i}; endproperty
	a_ovr: assert property (p_ovr) else $error("pin mode");
	property p_rd; reg_addr_i == 8'h33 |=>
		(reg_rdata_o & 8'hf7) == 8'h00; endproperty
	a_rd: assert property (p_rd) else $error("unused bits");
endmodule
bind output_driver_config_regs output_driver_config_regs_sva
	output_driver_config_regs_sva_inst (.*);

// File: bench/tb.sv
// Random self-checking bench of the output driver registers.
`timescale 1ns/1ps
`define CHK(x, y) begin samples_checked++; if ((x) !== (y)) begin \
	errors++; $display("Error %0t mismatch", $time); end end
module tb;
	logic c = 0, r = 0, w = 0, p = 0;
	logic [7:0] a = 8'h32, d = 8'h00, na, nd, sh[3];
	wire [7:0] q;
	wire [6:0] pe, se;
	wire s;
	int errors = 0, samples_checked = 0, cyc = 0;
	output_driver_config_regs output_driver_config_regs_inst (.clk_sys_i(c),
		.rst_b_i(r), .reg_wr_i(w), .reg_addr_i(a), .reg_wdata_i(d),
		.reg_rdata_o(q), .output_standard_select_pin_i(p),
		.pri_drive_strong_o(pe[6]), .pri_power_down_o(pe[5]),
		.pri_mode_o(pe[4:2]), .pri_pol_o(pe[1:0]), .sec_src_reference_o(s),
		.sec_drive_strong_o(se[6]), .sec_power_down_o(se[5]),
		.sec_mode_o(se[4:2]), .sec_pol_o(se[1:0]));
	// Without override the pin picks the mode and the rest keep defaults.
	function logic [6:0] eff(logic [7:0] v);
		if (!v[0]) return {4'b1010, p, 2'b00};
		return {v[7], v[6] | &v[5:4], v[5:3], v[5] ? 2'b00 : v[2:1]};
	endfunction
	task finish_test();
		if (errors == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	initial forever #2 c = ~c;
	always @(posedge c) if (++cyc == 2000) begin errors++; finish_test(); end
	initial begin
		void'($urandom(32'he690e1b3));
		sh = '{8'ha8, 8'h00, 8'ha8};
		repeat (20) @(posedge c);
		r <= 1;
		repeat (3) @(posedge c);
		// Four read-only passes first, then every mode code, then random.
		for (int i = 0; i < 300; i++) begin
			na = 8'h32 + 8'(i < 4 ? i : i < 20 ? 2 * i[0] : $urandom % 4);
			nd = i < 20 ? {2'b01, 3'(i >> 1), 3'b011} : 8'($urandom);
			@(posedge c);
			w <= i > 3;
			a <= na;
			d <= nd;
			p <= 1'($urandom);
			if (i > 3 && na < 8'h35)
				sh[na - 8'h32] = na == 8'h33 ? nd & 8'h08 : nd;
			@(posedge c);
			w <= 0;
			@(posedge c);
			#1;
			`CHK(q, a > 8'h34 ? 8'h00 : sh[a - 8'h32])
			`CHK(pe, eff(sh[0]))
			`CHK(se, eff(sh[2]))
			`CHK(s, sh[1][3])
		end
		finish_test();
	end
endmodule
